// [dbfs_defines.svh]
// Purpose: constants for the dual bank flash command sequencer
// Assumes: 16-bit cpu address, 8-bit data, 10 MHz ref_clk
// Notes: offsets, command codes and timing counts as macros
`ifndef DBFS_DEFINES_SVH
`define DBFS_DEFINES_SVH

// ----------------------------------------
// address map
// ----------------------------------------
`define DBFS_LOW_BASE 16'h1000
`define DBFS_LOW_LAST 16'h1FFF
`define DBFS_SEC1_BASE 16'h1800
`define DBFS_SEC2_BASE 16'h2000
`define DBFS_SEC3_BASE 16'h8000
`define DBFS_UNLOCK1_OFS 12'hAAA
`define DBFS_UNLOCK2_OFS 12'h554

// ----------------------------------------
// command codes
// ----------------------------------------
`define DBFS_CMD_RESET 8'hF0
`define DBFS_CMD_UNLOCK1 8'hAA
`define DBFS_CMD_UNLOCK2 8'h55
`define DBFS_CMD_PROGRAM 8'hA0
`define DBFS_CMD_ERASE 8'h80
`define DBFS_CMD_CHIP 8'h10
`define DBFS_CMD_SECTOR 8'h30
`define DBFS_CMD_SUSPEND 8'hB0
`define DBFS_CMD_BYPASS 8'h20
`define DBFS_CMD_BYP_EXIT 8'h90

// ----------------------------------------
// timing
// ----------------------------------------
`define DBFS_CLK_NS 100
`define DBFS_PROG_NS 2000
`define DBFS_ERASE_NS 6400
`define DBFS_PROG_CYC ((`DBFS_PROG_NS + `DBFS_CLK_NS - 1) / `DBFS_CLK_NS)
`define DBFS_ERASE_CYC ((`DBFS_ERASE_NS + `DBFS_CLK_NS - 1) / `DBFS_CLK_NS)
`define DBFS_SWE_RESET 4'h0

`endif

// [dbfs_pkg.sv]
// Purpose: shared types of the flash command sequencer
// Assumes: nothing beyond the defines header
// Notes: types only
package dbfs_pkg;
	typedef enum logic [1:0] {dbfs_op_none, dbfs_op_prog, dbfs_op_erase}
		dbfs_op_t;
endpackage

// [dbfs_if.sv]
// Purpose: cpu bus between flash sequencer and its controlling party
// Assumes: single clock, single cycle write strobe
// Notes: reads are answered on the next clock edge from a register
`timescale 1ns/100ps
`default_nettype none
interface dbfs_if (
	input wire logic ref_clk,
	input wire logic rst_n
);
	logic wr_en;
	logic rd_en;
	logic [15:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rd_valid;
	logic [3:0] sector_write_enable_reg;
	logic [1:0] bank_busy;
	logic done_irq;

	modport flash (input ref_clk, rst_n, wr_en, rd_en, addr, wdata,
		sector_write_enable_reg, output rdata, rd_valid, bank_busy,
		done_irq);
	modport cpu (input ref_clk, rst_n, rdata, rd_valid, bank_busy,
		done_irq, output wr_en, rd_en, addr, wdata,
		sector_write_enable_reg);
endinterface
`default_nettype wire

// [dbfs_cpu_end.sv]
// Purpose: controlling party: issues command sequences and reads
// Assumes: user gives one request at a time, waits for req_ready
// Notes: refuses reads and writes to a busy bank, except the suspend command write
`timescale 1ns/100ps
`default_nettype none
`include "dbfs_defines.svh"

module dbfs_cpu_end (
	dbfs_if.cpu bus,
	input wire logic user_wr,
	input wire logic user_rd,
	input wire logic [15:0] user_addr,
	input wire logic [7:0] user_wdata,
	input wire logic [3:0] user_swe,
	output logic req_ready,
	output logic [7:0] user_rdata,
	output logic user_rvalid,
	output logic user_done
);
	logic target_bank;
	logic bank_free;
	logic [3:0] swe;

	// --------------------------------------
	// access steering
	// --------------------------------------
	// upper bank is any address above the lower bank end
	assign target_bank = (user_addr > `DBFS_LOW_LAST);
	assign bank_free = !bus.bank_busy[target_bank];
	assign req_ready = bank_free;
	assign bus.wr_en = user_wr && (bank_free || user_wdata ==
		`DBFS_CMD_SUSPEND);
	assign bus.rd_en = user_rd && bank_free;
	assign bus.addr = user_addr;
	assign bus.wdata = user_wdata;
	assign bus.sector_write_enable_reg = swe;

	// write enables registered from user_swe on every clock, one cycle late
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			swe <= `DBFS_SWE_RESET;
		end else begin
			swe <= user_swe;
		end
	end

	// read data and completion captured in flops
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			user_rdata <= 8'h00;
			user_rvalid <= 1'b0;
			user_done <= 1'b0;
		end else begin
			user_rvalid <= bus.rd_valid;
			user_done <= bus.done_irq;
			if (bus.rd_valid) begin
				user_rdata <= bus.rdata;
			end
		end
	end
endmodule
`default_nettype wire

// [dbfs_flash_end.sv]
// Purpose: command decoder and bank arbiter of a two bank flash
// Assumes: array is a byte store of flops, 16 bytes per sector shown
// Notes: array holds 16 bytes per sector, low address bits index it
`timescale 1ns/100ps
`default_nettype none
`include "dbfs_defines.svh"

module dbfs_flash_end (
	dbfs_if.flash bus,
	output logic [3:0] erasing_sectors,
	output logic erase_suspended
);
	typedef enum logic [3:0] {dbfs_idle, dbfs_u1, dbfs_u2, dbfs_prog_data,
		dbfs_e1, dbfs_e2, dbfs_e3, dbfs_byp, dbfs_byp_data, dbfs_byp_exit}
		dbfs_seq_t;

	dbfs_seq_t seq;
	dbfs_seq_t next_seq;
	logic bypass;
	logic next_bypass;
	logic [7:0] mem [0:63];
	logic [5:0] wr_idx;
	logic [5:0] rd_idx;
	logic [1:0] wr_sec;
	logic [1:0] rd_sec;
	logic [11:0] ofs;
	logic wr_bank;
	logic rd_bank;
	dbfs_pkg::dbfs_op_t prog_op;
	logic [1:0] prog_sec;
	logic [5:0] prog_idx;
	logic [7:0] prog_val;
	logic [7:0] prog_cnt;
	logic start_prog;
	logic [3:0] erase_set;
	logic erase_run;
	logic erase_chip;
	logic [7:0] erase_cnt;
	logic start_erase;
	logic add_sector;
	logic do_suspend;
	logic do_resume;
	logic prog_bank;
	logic prog_busy;
	logic erase_fin;

	// --------------------------------------
	// address decode
	// --------------------------------------
	// four sectors; low two in lower bank
	function automatic logic [1:0] sec_of(input logic [15:0] a);
		if (a < `DBFS_SEC1_BASE) begin
			sec_of = 2'd0;
		end else if (a < `DBFS_SEC2_BASE) begin
			sec_of = 2'd1;
		end else if (a < `DBFS_SEC3_BASE) begin
			sec_of = 2'd2;
		end else begin
			sec_of = 2'd3;
		end
	endfunction

	assign wr_sec = sec_of(bus.addr);
	assign rd_sec = wr_sec;
	assign wr_bank = wr_sec[1];
	assign rd_bank = rd_sec[1];
	assign ofs = bus.addr[11:0];
	assign wr_idx = {wr_sec, bus.addr[3:0]};
	assign rd_idx = wr_idx;
	assign prog_busy = (prog_op == dbfs_pkg::dbfs_op_prog);
	assign prog_bank = prog_sec[1];
	// last erase count only ends the erase if nothing else claims the engine
	assign erase_fin = erase_run && erase_cnt == 8'h01 && !start_erase &&
		!add_sector && !do_suspend;

	// --------------------------------------
	// command sequence decode
	// --------------------------------------
	// next step of the unlock sequence, any mismatch goes back to read
	always_comb begin
		next_seq = dbfs_idle;
		next_bypass = bypass;
		start_prog = 1'b0;
		start_erase = 1'b0;
		add_sector = 1'b0;
		do_suspend = 1'b0;
		do_resume = 1'b0;
		if (!bus.wr_en) begin
			next_seq = seq;
		end else if (bus.wdata == `DBFS_CMD_RESET && seq != dbfs_byp_exit
			&& seq != dbfs_prog_data && seq != dbfs_byp_data) begin
			next_seq = dbfs_idle;
		end else if (erase_run && bus.wdata == `DBFS_CMD_SUSPEND) begin
			do_suspend = 1'b1;
		end else if (erase_set != 4'h0 && !erase_run && erase_cnt != 8'h00
			&& bus.wdata == `DBFS_CMD_SECTOR && seq == dbfs_idle) begin
			do_resume = 1'b1;
		end else begin
			case (seq)
			dbfs_idle: begin
				if (bypass && bus.wdata == `DBFS_CMD_PROGRAM) begin
					next_seq = dbfs_byp_data;
				end else if (bypass && bus.wdata == `DBFS_CMD_BYP_EXIT) begin
					next_seq = dbfs_byp_exit;
				end else if (bypass) begin
					next_seq = dbfs_byp;
				end else if (bus.wdata == `DBFS_CMD_UNLOCK1 &&
					ofs == `DBFS_UNLOCK1_OFS) begin
					next_seq = dbfs_u1;
				end
			end
			dbfs_u1: begin
				if (bus.wdata == `DBFS_CMD_UNLOCK2 &&
					ofs == `DBFS_UNLOCK2_OFS) begin
					next_seq = dbfs_u2;
				end
			end
			dbfs_u2: begin
				if (ofs != `DBFS_UNLOCK1_OFS) begin
					next_seq = dbfs_idle;
				end else if (bus.wdata == `DBFS_CMD_PROGRAM) begin
					next_seq = dbfs_prog_data;
				end else if (bus.wdata == `DBFS_CMD_ERASE) begin
					next_seq = dbfs_e1;
				end else if (bus.wdata == `DBFS_CMD_BYPASS) begin
					next_bypass = 1'b1;
				end
			end
			dbfs_prog_data, dbfs_byp_data: begin
				start_prog = 1'b1;
				next_seq = bypass ? dbfs_byp : dbfs_idle;
			end
			dbfs_e1: begin
				if (bus.wdata == `DBFS_CMD_UNLOCK1 &&
					ofs == `DBFS_UNLOCK1_OFS) begin
					next_seq = dbfs_e2;
				end
			end
			dbfs_e2: begin
				if (bus.wdata == `DBFS_CMD_UNLOCK2 &&
					ofs == `DBFS_UNLOCK2_OFS) begin
					next_seq = dbfs_e3;
				end
			end
			dbfs_e3: begin
				if (bus.wdata == `DBFS_CMD_CHIP && ofs == `DBFS_UNLOCK1_OFS
					&& &bus.sector_write_enable_reg) begin
					start_erase = 1'b1;
				end else if (bus.wdata == `DBFS_CMD_SECTOR) begin
					add_sector = 1'b1;
				end
			end
			dbfs_byp_exit: begin
				next_bypass = 1'b0;
			end
			default: begin
				next_seq = dbfs_idle;
			end
			endcase
			// further sector adds while erase not yet started
			if (seq == dbfs_idle && !bypass && erase_set != 4'h0 &&
				erase_cnt == 8'h00 && bus.wdata == `DBFS_CMD_SECTOR) begin
				add_sector = 1'b1;
			end
		end
	end

	// sequence state and bypass mode
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			seq <= dbfs_idle;
			bypass <= 1'b0;
		end else begin
			seq <= (next_seq == dbfs_byp) ? dbfs_idle : next_seq;
			bypass <= next_bypass;
		end
	end

	// --------------------------------------
	// program engine
	// --------------------------------------
	// program may start while the other bank's erase is suspended
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			prog_op <= dbfs_pkg::dbfs_op_none;
			prog_sec <= 2'd0;
			prog_idx <= 6'd0;
			prog_val <= 8'h00;
			prog_cnt <= 8'h00;
		end else if (start_prog && !prog_busy && (!erase_run ||
			erase_set[wr_sec] == 1'b0) && bus.sector_write_enable_reg[wr_sec])
			begin
			prog_op <= dbfs_pkg::dbfs_op_prog;
			prog_sec <= wr_sec;
			prog_idx <= wr_idx;
			prog_val <= bus.wdata;
			prog_cnt <= 8'(`DBFS_PROG_CYC);
		end else if (prog_busy && prog_cnt == 8'h01) begin
			prog_op <= dbfs_pkg::dbfs_op_none;
			prog_cnt <= 8'h00;
		end else if (prog_busy) begin
			prog_cnt <= prog_cnt - 8'h01;
		end
	end

	// --------------------------------------
	// erase engine
	// --------------------------------------
	// sector set, run and suspend; chip erase claims both banks
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			erase_set <= 4'h0;
			erase_run <= 1'b0;
			erase_chip <= 1'b0;
			erase_cnt <= 8'h00;
		end else if (start_erase) begin
			erase_set <= 4'hF;
			erase_chip <= 1'b1;
			erase_run <= 1'b1;
			erase_cnt <= 8'(`DBFS_ERASE_CYC);
		end else if (add_sector && bus.sector_write_enable_reg[wr_sec]) begin
			erase_set[wr_sec] <= 1'b1;
			erase_run <= 1'b1;
		end else if (do_suspend) begin
			erase_run <= 1'b0;
		end else if (do_resume) begin
			erase_run <= 1'b1;
		end else if (erase_run && erase_cnt == 8'h00) begin
			erase_cnt <= 8'(`DBFS_ERASE_CYC);
		end else if (erase_run && erase_cnt == 8'h01) begin
			erase_set <= 4'h0;
			erase_run <= 1'b0;
			erase_chip <= 1'b0;
			erase_cnt <= 8'h00;
		end else if (erase_run) begin
			erase_cnt <= erase_cnt - 8'h01;
		end
	end

	// --------------------------------------
	// array storage
	// --------------------------------------
	// one generate entry per byte: program clears bits, erase sets them
	genvar gi;
	generate
		for (gi = 0; gi < 64; gi++) begin : g_cell
			always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
				if (!bus.rst_n) begin
					mem[gi] <= 8'hFF;
				end else if (erase_fin && erase_set[gi / 16]) begin
					mem[gi] <= 8'hFF;
				end else if (prog_busy && prog_cnt == 8'h01 &&
					prog_idx == 6'(gi)) begin
					mem[gi] <= mem[gi] & prog_val;
				end
			end
		end
	endgenerate

	// --------------------------------------
	// status, reads and completion
	// --------------------------------------
	// bank busy flags; suspended erase frees its bank for reads
	assign bus.bank_busy[0] = (prog_busy && !prog_bank) ||
		(erase_run && |erase_set[1:0]);
	assign bus.bank_busy[1] = (prog_busy && prog_bank) ||
		(erase_run && |erase_set[3:2]);
	assign erasing_sectors = erase_set;
	assign erase_suspended = (erase_set != 4'h0) && !erase_run;

	// read answered on the next edge
	always_ff @(posedge bus.ref_clk or negedge bus.rst_n) begin
		if (!bus.rst_n) begin
			bus.rdata <= 8'h00;
			bus.rd_valid <= 1'b0;
			bus.done_irq <= 1'b0;
		end else begin
			bus.rd_valid <= bus.rd_en;
			bus.done_irq <= (prog_busy && prog_cnt == 8'h01) ||
				erase_fin;
			if (bus.rd_en && prog_busy && rd_sec == prog_sec) begin
				bus.rdata <= {~prog_val[7], 7'h00};
			end else if (bus.rd_en && erase_set[rd_sec]) begin
				bus.rdata <= 8'h00;
			end else if (bus.rd_en) begin
				bus.rdata <= mem[rd_idx];
			end
		end
	end
endmodule
`default_nettype wire

// [dbfs_seq_sva.sv]
// Purpose: bus checks between the two ends of the flash sequencer
// Assumes: one clock, asynchronous active low reset
// Notes: unlock progress is tracked in helper state
`timescale 1ns/100ps
`default_nettype none
module dbfs_seq_sva (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [15:0] addr,
	input wire logic [7:0] wdata,
	input wire logic [7:0] rdata,
	input wire logic rd_valid,
	input wire logic [3:0] sector_write_enable_reg,
	input wire logic [1:0] bank_busy,
	input wire logic done_irq
);
	// ----
	// unlock tracking
	// ----
	logic [2:0] stp;
	wire logic aaa = addr[11:0] == 12'haaa;
	wire logic bnk = addr >= 16'h2000;
	wire logic [1:0] sec = addr < 16'h1800 ? 2'h0 : bnk ?
		(addr < 16'h8000 ? 2'h2 : 2'h3) : 2'h1;
	wire logic u55 = addr[11:0] == 12'h554 && wdata == 8'h55;
	wire logic swe = sector_write_enable_reg[sec];

	// step reached by the latest writes, 6 after five erase writes
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			stp <= 3'h0;
		else if (wr_en)
			stp <= (aaa && wdata == 8'haa) ? ((stp == 3'h4) ? 3'h5 : 3'h1) :
				u55 ? ((stp == 3'h1) ? 3'h2 : (stp == 3'h5) ? 3'h6 : 3'h0) :
				(aaa && stp == 3'h2 && wdata == 8'ha0) ? 3'h3 :
				(aaa && stp == 3'h2 && wdata == 8'h80) ? 3'h4 : 3'h0;
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	chk_read_one_cycle: assert property (rd_en |=> rd_valid)
		else $error("read not answered");
	chk_rdata_hold: assert property ($changed(rdata) |-> rd_valid)
		else $error("read data moved");
	chk_busy_read: assert property (rd_en |-> !bank_busy[bnk])
		else $error("read of busy bank");
	chk_busy_write_block: assert property
		(wr_en && wdata != 8'hb0 |-> !bank_busy[bnk])
		else $error("write to busy bank");
	chk_irq_cause: assert property
		(done_irq |-> $past(bank_busy) != 2'b00)
		else $error("done without busy");
	chk_irq_pulse: assert property (done_irq |=> !done_irq)
		else $error("done too long");
	chk_prog_start: assert property
		(wr_en && stp == 3'h3 && swe && bank_busy == 2'b00
		|=> bank_busy[bnk] ##[18:22] done_irq)
		else $error("program not run");
	chk_chip_refused: assert property
		(wr_en && stp == 3'h6 && aaa && wdata == 8'h10 &&
		sector_write_enable_reg != 4'hf && bank_busy == 2'b00
		|=> (bank_busy == 2'b00) [*8])
		else $error("chip erase not ignored");
	chk_chip_both_banks: assert property
		(wr_en && stp == 3'h6 && aaa && wdata == 8'h10 &&
		sector_write_enable_reg == 4'hf && bank_busy == 2'b00
		|-> ##[1:3] bank_busy == 2'b11)
		else $error("chip erase not run");
	chk_sector_start: assert property
		(wr_en && stp == 3'h6 && wdata == 8'h30 && swe && !bank_busy[bnk]
		|-> ##[1:3] bank_busy[bnk])
		else $error("sector erase not run");

	cover property (rd_en && bank_busy != 2'b00);
	cover property (bank_busy == 2'b11);
	cover property (done_irq);
endmodule
`default_nettype wire

// [test_dual_bank_flash_command_sequencer.sv]
// Purpose: self-checking bench for both ends of the flash sequencer
// Assumes: reset and erased bytes read as ff
// Notes: reads are checked in order by a watcher process
`timescale 1ns/100ps
`default_nettype none
module test_dual_bank_flash_command_sequencer;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic user_wr = 1'b0;
	logic user_rd = 1'b0;
	logic [15:0] user_addr = 16'h1000;
	logic [7:0] user_wdata = 8'h00;
	logic [3:0] user_swe = 4'hf;
	logic req_ready;
	logic [7:0] user_rdata;
	logic user_rvalid;
	logic user_done;
	logic [3:0] erasing_sectors;
	logic erase_suspended;
	int bad_count = 0;
	int num_checks = 0;
	logic [15:0] seed = 16'h12c7;
	logic [7:0] expq[$];
	logic [7:0] mem[4];
	logic [15:0] base[4] = '{16'h1000, 16'h1800, 16'h2000, 16'h8000};
	logic [7:0] d;

	// clock
	always #50 ref_clk = ~ref_clk;

	dbfs_if dbfs_if_inst (.ref_clk(ref_clk), .rst_n(rst_n));
	dbfs_cpu_end dbfs_cpu_end_inst (.bus(dbfs_if_inst), .user_wr(user_wr),
		.user_rd(user_rd), .user_addr(user_addr), .user_wdata(user_wdata),
		.user_swe(user_swe), .req_ready(req_ready), .user_rdata(user_rdata),
		.user_rvalid(user_rvalid), .user_done(user_done));
	dbfs_flash_end dbfs_flash_end_inst (.bus(dbfs_if_inst),
		.erasing_sectors(erasing_sectors), .erase_suspended(erase_suspended));
	dbfs_seq_sva dbfs_seq_sva_inst (.ref_clk(ref_clk), .rst_n(rst_n),
		.wr_en(dbfs_if_inst.wr_en), .rd_en(dbfs_if_inst.rd_en),
		.addr(dbfs_if_inst.addr), .wdata(dbfs_if_inst.wdata),
		.rdata(dbfs_if_inst.rdata), .rd_valid(dbfs_if_inst.rd_valid),
		.sector_write_enable_reg(dbfs_if_inst.sector_write_enable_reg),
		.bank_busy(dbfs_if_inst.bank_busy), .done_irq(dbfs_if_inst.done_irq));

	// next random byte from the shift register
	function automatic logic [7:0] rnd();
		seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
		return seed[7:0];
	endfunction

	task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			$display("wrong value %s expected %h seen %h", s, e, g);
			bad_count++;
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// one request; a read queues its expected byte
	task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] v);
		int n;
		n = 0;
		@(posedge ref_clk);
		#1;
		user_addr = a;
		user_wdata = v;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
			if (n > 300) begin
				chk("ready wait", 8'h01, 8'h00);
				summarize();
			end
		end while (req_ready !== 1'b1 && !(w && v == 8'hb0));
		if (w)
			user_wr = 1'b1;
		else begin
			user_rd = 1'b1;
			expq.push_back(v);
		end
		@(posedge ref_clk);
		#1;
		user_wr = 1'b0;
		user_rd = 1'b0;
	endtask

	task automatic unl(input logic [3:0] u, input logic [7:0] c);
		xfer(1'b1, {u, 12'haaa}, 8'haa);
		xfer(1'b1, {u, 12'h554}, 8'h55);
		xfer(1'b1, {u, 12'haaa}, c);
	endtask

	task automatic ers(input logic [3:0] u, input logic [15:0] a, input logic [7:0] c);
		unl(u, 8'h80);
		xfer(1'b1, {u, 12'haaa}, 8'haa);
		xfer(1'b1, {u, 12'h554}, 8'h55);
		xfer(1'b1, a, c);
	endtask

	task automatic wait_done(input logic e);
		logic seen;
		seen = 1'b0;
		for (int n = 0; n < 150 && !seen; n++) begin
			@(posedge ref_clk);
			#1;
			seen = user_done === 1'b1;
		end
		chk("done pulse", {7'h00, e}, {7'h00, seen});
		if (e && !seen)
			summarize();
	endtask

	// compare each read answer with the oldest note
	always @(negedge ref_clk) begin
		if (user_rvalid === 1'b1) begin
			if (expq.size() == 0)
				chk("read count", 8'h00, 8'hff);
			else
				chk("read data", expq.pop_front(), user_rdata);
		end
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		#1 rst_n = 1'b1;
		for (int i = 0; i < 4; i++) begin
			mem[i] = 8'hff;
			xfer(1'b0, base[i] | {8'h00, rnd() & 8'h0f}, 8'hff);
		end
		$display("test reset read done");
		for (int i = 0; i < 4; i++) begin
			d = rnd();
			unl(base[i][15:12], 8'ha0);
			xfer(1'b1, base[i] + 16'h0003, d);
			xfer(1'b0, base[i ^ 2] + 16'h0003, mem[i ^ 2]);
			wait_done(1'b1);
			mem[i] = d;
			xfer(1'b0, base[i] + 16'h0003, d);
		end
		$display("test program done");
		user_swe = 4'h7;
		ers(4'h1, 16'h1aaa, 8'h10);
		wait_done(1'b0);
		xfer(1'b0, 16'h1003, mem[0]);
		user_swe = 4'hf;
		ers(4'h1, 16'h1aaa, 8'h10);
		wait_done(1'b1);
		for (int i = 0; i < 4; i++)
			xfer(1'b0, base[i] + 16'h0003, 8'hff);
		$display("test chip erase done");
		d = rnd();
		unl(4'h2, 8'ha0);
		xfer(1'b1, 16'h2003, d);
		wait_done(1'b1);
		ers(4'h2, 16'h2003, 8'h30);
		xfer(1'b1, 16'h2000, 8'hb0);
		repeat (3) @(posedge ref_clk);
		#1;
		chk("erase set", 8'h04, {4'h0, erasing_sectors});
		chk("suspended", 8'h01, {7'h00, erase_suspended});
		xfer(1'b0, 16'h2003, 8'h00);
		unl(4'h1, 8'ha0);
		xfer(1'b1, 16'h1003, d);
		wait_done(1'b1);
		xfer(1'b0, 16'h1003, d);
		xfer(1'b1, 16'h2000, 8'h30);
		wait_done(1'b1);
		xfer(1'b0, 16'h2003, 8'hff);
		$display("test suspend done");
		unl(4'h1, 8'h20);
		for (int j = 0; j < 3; j++) begin
			xfer(1'b1, 16'h1000, j < 2 ? 8'ha0 : 8'h90);
			xfer(1'b1, 16'h1008 + 16'(j), 8'h3c + 8'(j));
			wait_done(j < 2);
		end
		xfer(1'b1, 16'h1000, 8'ha0);
		xfer(1'b1, 16'h100b, 8'h5a);
		wait_done(1'b0);
		for (int j = 0; j < 4; j++)
			xfer(1'b0, 16'h1008 + 16'(j), j < 2 ? 8'h3c + 8'(j) : 8'hff);
		$display("test bypass done");
		for (int k = 0; k < 2; k++) begin
			xfer(1'b1, 16'h1aaa, 8'haa);
			xfer(1'b1, k ? 16'h1123 : 16'h1000, k ? 8'h55 : 8'hf0);
			xfer(1'b1, 16'h1aaa, 8'ha0);
			xfer(1'b1, 16'h100c, 8'h5a);
			wait_done(1'b0);
			xfer(1'b0, 16'h100c, 8'hff);
		end
		$display("test abandon done");
		repeat (4) @(posedge ref_clk);
		chk("pending reads", 8'h00, 8'(expq.size()));
		summarize();
	end
endmodule
`default_nettype wire
